// File: drs_pkg.sv
// Constants and carrier types for the drive run sequencer.
// Assumes a single 100 MHz clock shared with the control logic and register port.
//
// Behaviour
// - State code 0..7 reports sequencing state; zero after reset.
// - Direction request flag is remote reverse combined with reverse run command.
// - Health flag clears on trip, sets again when run is withdrawn; set at reset.
// - Fan output on while heatsink hot, ambient high or motor load high.
// - Fan output held a further 60 s after all fan demands go away.
// - Fan-at-power-on variant: fan on at reset, off 60 s after stop.
// - Entering powered-waiting drives contactor and starts timeout counter together.
// - Stay powered-waiting until contactor feedback true, then go ready.
// - Feedback still false when timeout reaches programmed delay raises contactor trip.
// - System reset pulse one cycle on entering run or jog.
// - Trips clear on remote clear rising edge, or run edge when enabled.
// - Power-up start enters powered-waiting if remote and run already present.
package drs_pkg;

  localparam int CLK_HZ           = 100_000_000;
  localparam int TICK_MS          = 100;
  localparam int TICK_CYCLES      = CLK_HZ / 1000 * TICK_MS;
  localparam int FAN_HOLD_S       = 60;
  localparam int FAN_HOLD_TICKS   = FAN_HOLD_S * 1000 / TICK_MS;
  // Delay is held in tenths of a second, which matches the tick
  localparam logic [7:0] CDLY_MIN   = 8'h0a;
  localparam logic [7:0] CDLY_MAX   = 8'h64;
  localparam logic [7:0] CDLY_RESET = 8'h64;

  localparam logic [3:0] ADDR_CTRL   = 4'h0;
  localparam logic [3:0] ADDR_CDLY   = 4'h1;
  localparam logic [3:0] ADDR_STATUS = 4'h2;
  localparam logic [3:0] ADDR_IRQ    = 4'h3;
  localparam logic [3:0] ADDR_MASK   = 4'h4;

  localparam int CTRL_CLR_ON_RUN = 0;
  localparam int CTRL_PWR_START  = 1;
  localparam logic [7:0] CTRL_RESET = 8'h01;

  localparam int IRQ_TRIP    = 0;
  localparam int IRQ_CFB     = 1;
  localparam int IRQ_SYSRST  = 2;
  localparam int IRQ_W       = 3;

  typedef enum logic [2:0] {
    ST_START_INHIBIT,
    ST_START_PERMIT,
    st_powered_waiting,
    ST_READY,
    ST_ENABLED,
    ST_FAST_STOP,
    ST_TRIP_ACTIVE,
    st_fault_latched
  } drs_state_t;

  typedef struct packed {
    logic run;
    logic jog;
    logic run_reverse;
    logic remote_reverse;
    logic remote;
    logic drive_enable;
    logic fast_stop_n;
    logic coast_stop_n;
    logic stopped;
    logic trip_in;
    logic remote_fault_clear;
    logic contactor_closed;
  } drs_cmd_t;

  typedef struct packed {
    logic heatsink_hot;
    logic ambient_high;
    logic load_high;
  } drs_fan_t;

endpackage : drs_pkg

// File: drs_sequencer.sv
// Run-state sequencer: state code, contactor handshake, health, direction and fan outputs.
// Assumes commands are synchronous to clk and a register master on the plain port.
//
// The address-and-strobe port and the address map were chosen for this implementation.
module drs_sequencer #(
  parameter int TICK_CYCLES    = drs_pkg::TICK_CYCLES,
  parameter int FAN_HOLD_TICKS = drs_pkg::FAN_HOLD_TICKS,
  parameter bit FAN_AT_POWERON = 1'b0
) (
  input  wire logic             clk,
  input  wire logic             nrst,
  input  wire drs_pkg::drs_cmd_t cmd,
  input  wire drs_pkg::drs_fan_t fan_dmd,
  input  wire logic [3:0]       addr,
  input  wire logic [7:0]       wdata,
  input  wire logic             wr,
  input  wire logic             rd,
  output logic [7:0]            rdata,
  output logic [2:0]            state_code,
  output logic                  contactor_out,
  output logic                  dir_request_flag,
  output logic                  health_flag,
  output logic                  fan_run_out,
  output logic                  contactor_fb_fault,
  output logic                  sys_reset_out,
  output logic                  irq
);

  localparam int TW = $clog2(TICK_CYCLES + 1);
  localparam int FW = $clog2(FAN_HOLD_TICKS + 1);
  localparam int IRQ_W_L = drs_pkg::IRQ_W;

  drs_pkg::drs_state_t state;
  drs_pkg::drs_state_t next_state;
  logic [7:0]          ctrl;
  logic [7:0]          cdly;
  logic [IRQ_W_L-1:0]  irq_stat;
  logic [IRQ_W_L-1:0]  irq_mask;
  logic [TW-1:0]       pre_cnt;
  logic                tick;
  logic [7:0]          ctr_cnt;
  logic [FW-1:0]       fan_cnt;
  logic                run_q;
  logic                clr_q;
  logic                fault;
  logic                first;
  logic                run_rise;
  logic                clr_rise;
  logic                clear_trips;
  logic                cfb_timeout;
  logic                fan_any;
  logic                enter_run;
  logic                pwr_start;

  ////////////////////////////////////////////////////////////////////////////
  // Prescaler and edge detection
  // One prescaler serves both slow timers, so each long count needs only a few bits
  // Tick phase is free-running, so every timeout carries up to one tick of jitter

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pre_cnt <= '0;
      tick    <= 1'b0;
    end else if (pre_cnt == TW'(TICK_CYCLES - 1)) begin
      pre_cnt <= '0;
      tick    <= 1'b1;
    end else begin
      pre_cnt <= pre_cnt + TW'(1);
      tick    <= 1'b0;
    end
  end

  // Power-up flag lets power-up start act on a run that was already present
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      run_q <= 1'b0;
      clr_q <= 1'b0;
      first <= 1'b1;
    end else begin
      run_q <= cmd.run | cmd.jog;
      clr_q <= cmd.remote_fault_clear;
      // Power-up window lasts until the sequencer first leaves start-inhibit
      first <= first & (next_state == drs_pkg::ST_START_INHIBIT);
    end
  end

  // A run already present at power-up is not an edge; only power-up start may use it
  assign pwr_start   = first & ctrl[drs_pkg::CTRL_PWR_START] & cmd.remote & (cmd.run | cmd.jog);
  assign run_rise    = (cmd.run | cmd.jog) & ~run_q & ~first;
  assign clr_rise    = cmd.remote_fault_clear & ~clr_q;
  assign clear_trips = clr_rise | (run_rise & ctrl[drs_pkg::CTRL_CLR_ON_RUN]);
  assign cfb_timeout = (state == drs_pkg::st_powered_waiting) & ~cmd.contactor_closed &
                       (ctr_cnt >= cdly);
  assign fan_any     = fan_dmd.heatsink_hot | fan_dmd.ambient_high | fan_dmd.load_high;

  ////////////////////////////////////////////////////////////////////////////
  // Sequencing state machine
  // Trip and coast overrides follow the case so they win over its transitions, except out of fault-latched, and out of trip-active for coast;
  // a trip input that is still held keeps the drive in trip-active until it drops

  always_comb begin
    next_state = state;
    case (state)
      drs_pkg::ST_START_INHIBIT: begin
        if (cmd.coast_stop_n && cmd.fast_stop_n) begin
          if (pwr_start)
            next_state = drs_pkg::st_powered_waiting;
          else if (!(cmd.run | cmd.jog))
            next_state = drs_pkg::ST_START_PERMIT;
        end
      end
      drs_pkg::ST_START_PERMIT: begin
        if (run_rise)
          next_state = drs_pkg::st_powered_waiting;
      end
      drs_pkg::st_powered_waiting: begin
        if (cfb_timeout)
          next_state = drs_pkg::ST_TRIP_ACTIVE;
        else if (cmd.contactor_closed)
          next_state = drs_pkg::ST_READY;
      end
      drs_pkg::ST_READY: begin
        if (cmd.drive_enable)
          next_state = drs_pkg::ST_ENABLED;
      end
      drs_pkg::ST_ENABLED: begin
        if (!cmd.fast_stop_n)
          next_state = drs_pkg::ST_FAST_STOP;
        else if (!(cmd.run | cmd.jog) && cmd.stopped)
          next_state = drs_pkg::ST_START_PERMIT;
      end
      drs_pkg::ST_FAST_STOP: begin
        if (cmd.stopped)
          next_state = drs_pkg::ST_START_INHIBIT;
      end
      drs_pkg::ST_TRIP_ACTIVE: begin
        if (cmd.stopped)
          next_state = drs_pkg::st_fault_latched;
      end
      drs_pkg::st_fault_latched: begin
        if (clear_trips)
          next_state = drs_pkg::ST_START_INHIBIT;
      end
      default: next_state = drs_pkg::ST_START_INHIBIT;
    endcase
    if (cmd.trip_in && state != drs_pkg::st_fault_latched)
      next_state = drs_pkg::ST_TRIP_ACTIVE;
    else if (!cmd.coast_stop_n && state != drs_pkg::ST_TRIP_ACTIVE &&
             state != drs_pkg::st_fault_latched)
      next_state = drs_pkg::ST_START_INHIBIT;
  end

  assign enter_run = (next_state == drs_pkg::ST_ENABLED) && (state != drs_pkg::ST_ENABLED);

  // The code is loaded with the next state, so it leaves a flip-flop yet tracks the
  // state register exactly; the reset pulse and interrupt status bits line up with it
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state      <= drs_pkg::ST_START_INHIBIT;
      state_code <= 3'h0;
    end else begin
      state      <= next_state;
      state_code <= 3'(next_state);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Contactor drive and timeout
  // The timeout counter saturates so a long wait cannot wrap back under the delay
  // Contactor stays driven after a normal stop; only a trip opens it

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      contactor_out <= 1'b0;
      ctr_cnt       <= 8'h00;
    end else begin
      if (next_state == drs_pkg::st_powered_waiting && state != drs_pkg::st_powered_waiting) begin
        contactor_out <= 1'b1;
        ctr_cnt       <= 8'h00;
      end else if (state == drs_pkg::st_powered_waiting && tick && ctr_cnt != 8'hff) begin
        ctr_cnt <= ctr_cnt + 8'h01;
      end
      if (next_state == drs_pkg::st_fault_latched || next_state == drs_pkg::ST_TRIP_ACTIVE)
        contactor_out <= 1'b0;
    end
  end

  // Contactor trip stays latched until the trips are cleared
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      contactor_fb_fault <= 1'b0;
    end else if (cfb_timeout) begin
      contactor_fb_fault <= 1'b1;
    end else if (state == drs_pkg::st_fault_latched && clear_trips) begin
      contactor_fb_fault <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flags and system reset pulse
  // Direction reflects the demand only; no motor feedback is used
  // Health drops on entry to trip and recovers once run and jog are both low

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      dir_request_flag <= 1'b0;
      health_flag      <= 1'b1;
      sys_reset_out    <= 1'b0;
    end else begin
      dir_request_flag <= cmd.remote_reverse ^ cmd.run_reverse;
      sys_reset_out    <= enter_run;
      if (next_state == drs_pkg::ST_TRIP_ACTIVE)
        health_flag <= 1'b0;
      else if (!(cmd.run | cmd.jog))
        health_flag <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Fan control

  // Without demand, the power-on variant only runs the hold-off once the drive has stopped
  // Any new demand restarts the full hold-off
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      fan_run_out <= FAN_AT_POWERON;
      fan_cnt     <= '0;
    end else if (fan_any) begin
      fan_run_out <= 1'b1;
      fan_cnt     <= '0;
    end else if (fan_run_out && (!FAN_AT_POWERON || cmd.stopped)) begin
      if (fan_cnt >= FW'(FAN_HOLD_TICKS)) begin
        fan_run_out <= 1'b0;
        fan_cnt     <= '0;
      end else if (tick) begin
        fan_cnt <= fan_cnt + FW'(1);
      end
    end else begin
      fan_cnt <= '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register port and interrupt
  // Delay writes outside the legal range are clamped rather than refused
  // Control keeps only the two defined bits; the rest read back as zero

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ctrl <= drs_pkg::CTRL_RESET;
      cdly <= drs_pkg::CDLY_RESET;
    end else if (wr) begin
      if (addr == drs_pkg::ADDR_CTRL)
        ctrl <= wdata & 8'h03;
      if (addr == drs_pkg::ADDR_CDLY) begin
        if (wdata < drs_pkg::CDLY_MIN)
          cdly <= drs_pkg::CDLY_MIN;
        else if (wdata > drs_pkg::CDLY_MAX)
          cdly <= drs_pkg::CDLY_MAX;
        else
          cdly <= wdata;
      end
    end
  end

  // Set wins over write-one-to-clear in the same cycle
  // Status bits: trip entry, contactor timeout, run entry; irq lags status by one cycle
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irq_stat <= '0;
      irq_mask <= '0;
      irq      <= 1'b0;
    end else begin
      if (wr && addr == drs_pkg::ADDR_MASK)
        irq_mask <= wdata[IRQ_W_L-1:0];
      irq_stat <= (irq_stat & ~((wr && addr == drs_pkg::ADDR_IRQ) ? wdata[IRQ_W_L-1:0] : '0)) |
                  {enter_run, cfb_timeout, next_state == drs_pkg::ST_TRIP_ACTIVE &&
                                           state != drs_pkg::ST_TRIP_ACTIVE};
      irq      <= |(irq_stat & irq_mask);
    end
  end

  // Read data stand for one cycle only and return to zero otherwise
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdata <= 8'h00;
    end else if (rd) begin
      case (addr)
        drs_pkg::ADDR_CTRL:   rdata <= ctrl;
        drs_pkg::ADDR_CDLY:   rdata <= cdly;
        drs_pkg::ADDR_STATUS: rdata <= {contactor_fb_fault, fan_run_out, health_flag,
                                        dir_request_flag, contactor_out, state_code};
        drs_pkg::ADDR_IRQ:    rdata <= {5'h00, irq_stat};
        drs_pkg::ADDR_MASK:   rdata <= {5'h00, irq_mask};
        default:              rdata <= 8'h00;
      endcase
    end else begin
      rdata <= 8'h00;
    end
  end

endmodule : drs_sequencer

// File: drs_sequencer_sva.sv
// Port checker for the run sequencer.
// Assumes the bench sets the small tick and hold parameters and keeps inputs low in reset.
module drs_sequencer_sva #(
  parameter int TICK_CYCLES    = 10,
  parameter int FAN_HOLD_TICKS = 5,
  parameter bit FAN_AT_POWERON = 1'b0
) (
  input wire logic              clk,
  input wire logic              nrst,
  input wire drs_pkg::drs_cmd_t cmd,
  input wire drs_pkg::drs_fan_t fan_dmd,
  input wire logic [2:0]        state_code,
  input wire logic              contactor_out,
  input wire logic              dir_request_flag,
  input wire logic              health_flag,
  input wire logic              fan_run_out,
  input wire logic              contactor_fb_fault,
  input wire logic              sys_reset_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // Margins of one tick cover the unknown prescaler phase
  localparam int LO   = (FAN_HOLD_TICKS - 1) * TICK_CYCLES;
  localparam int HI   = (FAN_HOLD_TICKS + 1) * TICK_CYCLES + 2;
  localparam int WLIM = 101 * TICK_CYCLES + 2;
  logic [31:0] idle_n;
  logic [31:0] wait_n;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) idle_n <= {32{!FAN_AT_POWERON}};
    else if (|fan_dmd) idle_n <= '0;
    else if (FAN_AT_POWERON && !cmd.stopped) idle_n <= fan_run_out ? 32'h0 : idle_n;
    else if (idle_n != '1) idle_n <= idle_n + 32'h1;
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) wait_n <= '0;
    else wait_n <= (state_code == 3'h2) ? wait_n + 32'h1 : '0;
  end
  ////////////////////////////////////////////////////////////////////////////
  a_dir_flag_xor: assert property ($past(nrst) |->
    dir_request_flag == $past(cmd.remote_reverse ^ cmd.run_reverse)) else $error("direction flag wrong");
  a_trip_health_low: assert property (state_code == 3'h6 && $past(state_code) == 3'h6
    && $past(cmd.run) |-> !health_flag) else $error("health high in trip");
  a_fan_on_demand: assert property (|fan_dmd |=> fan_run_out) else $error("fan not on");
  a_fan_hold_kept: assert property (idle_n >= 1 && idle_n < LO |-> fan_run_out) else $error("fan dropped early");
  a_fan_hold_end: assert property (idle_n > HI |-> !fan_run_out) else $error("fan held too long");
  a_wait_contactor: assert property ($rose(state_code == 3'h2) |-> contactor_out) else $error("no contactor drive");
  a_ready_on_fb: assert property ($rose(state_code == 3'h3) |->
    $past(state_code) == 3'h2 && $past(cmd.contactor_closed)) else $error("ready without feedback");
  a_cfb_cause: assert property ($rose(contactor_fb_fault) |->
    $past(state_code) == 3'h2 && !$past(cmd.contactor_closed)) else $error("bad contactor trip");
  a_cfb_bound: assert property (wait_n <= WLIM) else $error("contactor wait unbounded");
  a_sysrst_pulse: assert property (sys_reset_out |-> (state_code == 3'h4
    && $past(state_code) != 3'h4) ##1 !sys_reset_out) else $error("bad reset pulse");
  a_fault_open: assert property (state_code == 3'h7 |-> !contactor_out) else $error("contactor on in fault");
endmodule : drs_sequencer_sva

bind drs_sequencer drs_sequencer_sva #(.TICK_CYCLES(TICK_CYCLES), .FAN_HOLD_TICKS(FAN_HOLD_TICKS),
  .FAN_AT_POWERON(FAN_AT_POWERON)) u_sva (
  .clk, .nrst, .cmd, .fan_dmd, .state_code, .contactor_out, .dir_request_flag, .health_flag,
  .fan_run_out, .contactor_fb_fault, .sys_reset_out);

// File: drs_contactor_model.sv
// Model of the external power contactor and its feedback contact.
// Assumes drive is the contactor output of the sequencer; stuck models a welded-open coil.
module drs_contactor_model #(
  parameter int DLY = 4
) (
  input  wire logic clk,
  input  wire logic nrst,
  input  wire logic drive,
  input  wire logic stuck,
  output logic      closed
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt;
  // An open contact reads false, so released feedback never shows stale high
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst || !drive || stuck) begin
      cnt    <= 0;
      closed <= 1'b0;
    end else if (cnt >= DLY && !stuck) closed <= 1'b1;
    else cnt <= cnt + 1;
  end
endmodule : drs_contactor_model

// File: tb_drive_run_sequencer.sv
// Bench for the run sequencer with a contactor model on its handshake.
// Assumes a short tick and hold so the long timers finish quickly.
module tb_drive_run_sequencer;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TK = 10;
  localparam int FH = 5;
  logic clk, nrst, wr, rd, stuck, cc;
  logic [3:0] addr;
  logic [7:0] wdata, rdata;
  logic [2:0] state_code;
  logic contactor_out, dir_request_flag, health_flag, fan_run_out, contactor_fb_fault, sys_reset_out, irq;
  logic fan_po;
  drs_pkg::drs_cmd_t c, cmd;
  drs_pkg::drs_fan_t fan;
  int mismatches, checks, n, k;
  always_comb begin
    cmd = c;
    cmd.contactor_closed = cc;
  end
  drs_sequencer #(.TICK_CYCLES(TK), .FAN_HOLD_TICKS(FH)) DUT (.clk(clk), .nrst(nrst), .cmd(cmd),
    .fan_dmd(fan), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .state_code(state_code),
    .contactor_out(contactor_out), .dir_request_flag(dir_request_flag), .health_flag(health_flag),
    .fan_run_out(fan_run_out), .contactor_fb_fault(contactor_fb_fault), .sys_reset_out(sys_reset_out),
    .irq(irq));
  // Power-on fan variant shares every input; only its fan output is watched
  drs_sequencer #(.TICK_CYCLES(TK), .FAN_HOLD_TICKS(FH), .FAN_AT_POWERON(1'b1)) DUT_FAN (.clk(clk), .nrst(nrst),
    .cmd(cmd), .fan_dmd(fan), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(), .state_code(),
    .contactor_out(), .dir_request_flag(), .health_flag(), .fan_run_out(fan_po), .contactor_fb_fault(),
    .sys_reset_out(), .irq());
  drs_contactor_model u_ctr (.clk(clk), .nrst(nrst), .drive(contactor_out), .stuck(stuck), .closed(cc));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : give_verdict
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic cyc(input int m);
    repeat (m) @(posedge clk);
    #1;
  endtask : cyc
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    cyc(1);
    wr <= 1'b0;
    cyc(1);
  endtask : wr_reg
  task automatic rd_reg(input logic [3:0] a, input logic [7:0] exp);
    addr <= a;
    rd <= 1'b1;
    cyc(1);
    rd <= 1'b0;
    chk(rdata, exp);
    cyc(1);
  endtask : rd_reg
  // Bounded wait; n holds the cycles spent
  task automatic wait_st(input logic [2:0] e);
    n = 0;
    while (state_code !== e && n < 300) begin
      cyc(1);
      n++;
    end
    if (state_code !== e) begin
      mismatches++;
      give_verdict();
    end
  endtask : wait_st
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    c = '0; fan = '0; addr = '0; wdata = '0; wr = 1'b0; rd = 1'b0; stuck = 1'b0; nrst = 1'b0;
    mismatches = 0; checks = 0;
    cyc(12);
    nrst <= 1'b1;
    cyc(1);
    chk(8'(state_code), 8'h00);
    chk(8'(health_flag), 8'h01);
    chk(8'(fan_po), 8'h01);
    rd_reg(drs_pkg::ADDR_CTRL, drs_pkg::CTRL_RESET);
    rd_reg(drs_pkg::ADDR_CDLY, drs_pkg::CDLY_RESET);
    rd_reg(4'h5, 8'h00);
    rd_reg(drs_pkg::ADDR_STATUS, 8'h20);
    c.run_reverse <= 1'b1;
    cyc(2);
    chk(8'(dir_request_flag), 8'h01);
    c.remote_reverse <= 1'b1;
    cyc(2);
    chk(8'(dir_request_flag), 8'h00);
    c.run_reverse <= 1'b0;
    c.coast_stop_n <= 1'b1;
    c.fast_stop_n <= 1'b1;
    c.stopped <= 1'b1;
    wait_st(3'h1);
    c.run <= 1'b1;
    wait_st(3'h2);
    chk(8'(contactor_out), 8'h01);
    wait_st(3'h3);
    chk(8'(n >= 3), 8'h01);
    c.drive_enable <= 1'b1;
    wait_st(3'h4);
    k = int'(sys_reset_out === 1'b1);
    repeat (8) begin
      cyc(1);
      if (sys_reset_out === 1'b1) k++;
    end
    chk(8'(k), 8'h01);
    c.run <= 1'b0;
    c.drive_enable <= 1'b0;
    wait_st(3'h1);
    wr_reg(drs_pkg::ADDR_CDLY, 8'h05);
    rd_reg(drs_pkg::ADDR_CDLY, drs_pkg::CDLY_MIN);
    stuck <= 1'b1;
    c.run <= 1'b1;
    wait_st(3'h2);
    wait_st(3'h7);
    chk(8'(n >= 9 * TK && n <= 11 * TK + 3), 8'h01);
    chk(8'(contactor_fb_fault), 8'h01);
    chk(8'(contactor_out), 8'h00);
    chk(8'(health_flag), 8'h00);
    chk(8'(fan_po), 8'h00);
    rd_reg(drs_pkg::ADDR_IRQ, 8'h07);
    chk(8'(irq), 8'h00);
    wr_reg(drs_pkg::ADDR_MASK, 8'h02);
    chk(8'(irq), 8'h01);
    wr_reg(drs_pkg::ADDR_IRQ, 8'h03);
    cyc(1);
    chk(8'(irq), 8'h00);
    rd_reg(drs_pkg::ADDR_IRQ, 8'h04);
    c.run <= 1'b0;
    stuck <= 1'b0;
    cyc(3);
    chk(8'(health_flag), 8'h01);
    c.remote_fault_clear <= 1'b1;
    wait_st(3'h1);
    chk(8'(contactor_fb_fault), 8'h00);
    c.remote_fault_clear <= 1'b0;
    c.trip_in <= 1'b1;
    wait_st(3'h6);
    c.trip_in <= 1'b0;
    wait_st(3'h7);
    c.run <= 1'b1;
    wait_st(3'h0);
    c.run <= 1'b0;
    for (int i = 0; i < 3; i++) begin
      fan <= drs_pkg::drs_fan_t'(3'h1 << i);
      cyc(2);
      chk(8'(fan_run_out), 8'h01);
      fan <= '0;
      n = 0;
      while (fan_run_out === 1'b1 && n < 200) begin
        cyc(1);
        n++;
      end
      chk(8'(n >= (FH - 1) * TK && n <= (FH + 1) * TK + 3), 8'h01);
    end
    // Mid-run reset with run already present: held off until power-up start is set
    c.run <= 1'b1;
    c.remote <= 1'b1;
    nrst <= 1'b0;
    cyc(2);
    nrst <= 1'b1;
    cyc(2);
    chk(8'(state_code), 8'h00);
    wr_reg(drs_pkg::ADDR_CTRL, 8'h03);
    chk(8'(state_code), 8'h02);
    rd_reg(drs_pkg::ADDR_CTRL, 8'h03);
    give_verdict();
  end
endmodule : tb_drive_run_sequencer
